// ==== hw/nvssr_ctrl.sv ====
module nvssr_ctrl
	import nvssr_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	// Host access
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [NVSSR_ADDR_W-1:0] addr_in,
	input wire logic [NVSSR_DATA_W-1:0] wdata_in,
	output logic ack_out,
	output logic [NVSSR_DATA_W-1:0] rdata_out,
	// Software transfer requests
	input wire logic sw_store_in,
	input wire logic sw_recall_in,
	// Power monitor and status
	input wire logic supply_low_in,
	output logic store_capacitor_pin_isolate_out,
	output logic busy_out,
	output logic dirty_out
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// SRAM cells and their paired nonvolatile cells, one byte each
	logic [NVSSR_DATA_W-1:0] sram_mem [0:NVSSR_MEM_BYTES-1];
	logic [NVSSR_DATA_W-1:0] nv_mem [0:NVSSR_MEM_BYTES-1];

	// ----------------------------------------
	// State
	// ----------------------------------------
	nvssr_state_e state_r;
	nvssr_state_e state_nxt;
	logic [NVSSR_CNT_W-1:0] cnt_r;
	logic [NVSSR_CNT_W-1:0] cnt_nxt;
	logic dirty_r;
	logic dirty_nxt;
	logic store_pend_r;
	logic store_pend_nxt;
	logic recall_pend_r;
	logic recall_pend_nxt;
	logic iso_r;
	logic iso_nxt;
	logic busy_r;
	logic busy_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [NVSSR_DATA_W-1:0] rdata_r;
	logic accept;
	logic start_store;
	logic start_recall;
	logic store_done;
	logic recall_done;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	assign store_done = (state_r == NVSSR_STORE) && (cnt_r == '0);
	assign recall_done = (state_r == NVSSR_RECALL) && (cnt_r == '0);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		iso_nxt = iso_r;
		start_store = 1'b0;
		start_recall = 1'b0;
		accept = 1'b0;
		case (state_r)
			NVSSR_IDLE:
			begin
				if (supply_low_in)
				begin
					// Power loss wins over every software request
					iso_nxt = 1'b1;
					if (dirty_r)
					begin
						start_store = 1'b1;
					end
					else
					begin
						state_nxt = NVSSR_DOWN;
					end
				end
				else if (sw_store_in || store_pend_r)
				begin
					start_store = 1'b1;
				end
				else if (sw_recall_in || recall_pend_r)
				begin
					start_recall = 1'b1;
				end
				else
				begin
					accept = req_in;
				end
			end
			NVSSR_STORE:
			begin
				if (cnt_r == '0)
				begin
					state_nxt = iso_r ? NVSSR_DOWN : NVSSR_IDLE;
				end
				else
				begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			NVSSR_RECALL:
			begin
				if (cnt_r == '0)
				begin
					state_nxt = NVSSR_IDLE;
				end
				else
				begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			NVSSR_DOWN:
			begin
				// Supply back: reload the array before host access
				if (!supply_low_in)
				begin
					iso_nxt = 1'b0;
					start_recall = 1'b1;
				end
			end
			default:
			begin
				state_nxt = NVSSR_IDLE;
			end
		endcase
		if (start_store)
		begin
			state_nxt = NVSSR_STORE;
			cnt_nxt = NVSSR_STORE_CYC - 16'h0001;
		end
		if (start_recall)
		begin
			state_nxt = NVSSR_RECALL;
			cnt_nxt = NVSSR_RECALL_CYC - 16'h0001;
		end
	end

	// Requests seen while busy are held; a new one in the clear cycle stays only for a recall started from down
	always_comb
	begin
		store_pend_nxt = (store_pend_r && !start_store)
			|| (sw_store_in && (state_r != NVSSR_IDLE));
		recall_pend_nxt = (recall_pend_r && !start_recall)
			|| (sw_recall_in && (state_r != NVSSR_IDLE));
		// Accesses are only taken in idle, so a write never meets the clear
		dirty_nxt = dirty_r;
		if (store_done || recall_done)
		begin
			dirty_nxt = 1'b0;
		end
		if (accept && we_in)
		begin
			dirty_nxt = 1'b1;
		end
		busy_nxt = (state_nxt != NVSSR_IDLE);
		ack_nxt = accept;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset stands for power-up, so the controller opens with a recall
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_r <= NVSSR_RECALL;
			cnt_r <= NVSSR_CNT_RST;
			dirty_r <= 1'b0;
			store_pend_r <= 1'b0;
			recall_pend_r <= 1'b0;
			iso_r <= 1'b0;
			busy_r <= 1'b1;
			ack_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			dirty_r <= dirty_nxt;
			store_pend_r <= store_pend_nxt;
			recall_pend_r <= recall_pend_nxt;
			iso_r <= iso_nxt;
			busy_r <= busy_nxt;
			ack_r <= ack_nxt;
		end
	end

	// ----------------------------------------
	// Memory arrays
	// ----------------------------------------
	// Whole-array copy on one edge; slow to simulate, but it is the behaviour
	always_ff @(posedge ref_clk_in)
	begin
		if (store_done)
		begin
			for (int i = 0; i < NVSSR_MEM_BYTES; i++)
			begin
				nv_mem[i] <= sram_mem[i];
			end
		end
		if (recall_done)
		begin
			for (int i = 0; i < NVSSR_MEM_BYTES; i++)
			begin
				sram_mem[i] <= nv_mem[i];
			end
		end
		else if (accept && we_in)
		begin
			sram_mem[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rdata_r <= NVSSR_DATA_RST;
		end
		else if (accept && !we_in)
		begin
			rdata_r <= sram_mem[addr_in];
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign ack_out = ack_r;
	assign rdata_out = rdata_r;
	assign busy_out = busy_r;
	assign dirty_out = dirty_r;
	assign store_capacitor_pin_isolate_out = iso_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_no_access_busy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r != NVSSR_IDLE) |=> !ack_r)
		else $error("access answered during transfer");

	chk_busy_flag: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		start_store |=> busy_r [*2])
		else $error("busy not shown during store");

	chk_loss_store: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_IDLE && supply_low_in && dirty_r)
		|=> (state_r == NVSSR_STORE) && iso_r)
		else $error("dirty power loss did not store");

	chk_loss_skip: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_IDLE && supply_low_in && !dirty_r) |=> state_r == NVSSR_DOWN)
		else $error("clean power loss did not skip store");

	chk_sw_store: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_IDLE && !supply_low_in && sw_store_in)
		|=> state_r == NVSSR_STORE)
		else $error("software store not executed");

	chk_dirty_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(store_done || recall_done) |=> !dirty_r)
		else $error("dirty flag not cleared by transfer");

	chk_dirty_set: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(accept && we_in) |=> dirty_r && ack_r)
		else $error("write did not set dirty flag");

	chk_cap_isolate: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_IDLE && supply_low_in) |=> iso_r)
		else $error("capacitor not isolated on power loss");

	chk_cap_down: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_DOWN) |-> iso_r)
		else $error("capacitor reconnected while powered down");

	chk_store_length: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		start_store |=> (state_r == NVSSR_STORE) [*8] ##1 (state_r == NVSSR_STORE) [*2]
		##1 (state_r != NVSSR_STORE))
		else $error("store length wrong");

	chk_down_recall: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(state_r == NVSSR_DOWN && !supply_low_in) |=> state_r == NVSSR_RECALL)
		else $error("no recall after supply returned");

	chk_read_data: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(accept && !we_in) |=> (rdata_r == sram_mem[$past(addr_in)]))
		else $error("read data does not match SRAM");

endmodule

// ==== hw/nvssr_pkg.sv ====
package nvssr_pkg;

	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int unsigned NVSSR_MEM_BYTES = 262144;
	localparam int unsigned NVSSR_ADDR_W = 18;
	localparam int unsigned NVSSR_DATA_W = 8;

	// ----------------------------------------
	// Transfer timing
	// ----------------------------------------
	localparam int unsigned NVSSR_CLK_PERIOD_NS = 50;
	localparam int unsigned NVSSR_STORE_TIME_NS = 500;
	localparam int unsigned NVSSR_RECALL_TIME_NS = 200;
	localparam int unsigned NVSSR_CNT_W = 16;
	// Least times, rounded up to whole cycles, never below one
	localparam int unsigned NVSSR_STORE_CYC_I =
		(NVSSR_STORE_TIME_NS + NVSSR_CLK_PERIOD_NS - 1) / NVSSR_CLK_PERIOD_NS;
	localparam int unsigned NVSSR_RECALL_CYC_I =
		(NVSSR_RECALL_TIME_NS + NVSSR_CLK_PERIOD_NS - 1) / NVSSR_CLK_PERIOD_NS;
	localparam logic [NVSSR_CNT_W-1:0] NVSSR_STORE_CYC =
		NVSSR_CNT_W'((NVSSR_STORE_CYC_I < 1) ? 1 : NVSSR_STORE_CYC_I);
	localparam logic [NVSSR_CNT_W-1:0] NVSSR_RECALL_CYC =
		NVSSR_CNT_W'((NVSSR_RECALL_CYC_I < 1) ? 1 : NVSSR_RECALL_CYC_I);

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [NVSSR_CNT_W-1:0] NVSSR_CNT_RST = NVSSR_RECALL_CYC - 16'h0001;
	localparam logic [NVSSR_DATA_W-1:0] NVSSR_DATA_RST = 8'h00;

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		NVSSR_IDLE,
		NVSSR_STORE,
		NVSSR_RECALL,
		NVSSR_DOWN
	} nvssr_state_e;

endpackage

// ==== test/nvssr_ctrl_tb.sv ====
module nvssr_ctrl_tb
	import nvssr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(nm, e, g) check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end
	localparam logic [NVSSR_ADDR_W-1:0] a_top = 18'h3ffff;
	localparam logic [NVSSR_ADDR_W-1:0] a_low = 18'h00000;
	logic clk, rst_n, req, we, ack, busy, dirty, iso, st, rc, low;
	logic [NVSSR_ADDR_W-1:0] addr;
	logic [NVSSR_DATA_W-1:0] wd, rd, q;
	bit ok;
	int n, mismatches, check_count, ack_busy;
	nvssr_ctrl u_nvssr_ctrl (.ref_clk_in(clk), .arst_n_in(rst_n), .req_in(req), .we_in(we),
		.addr_in(addr), .wdata_in(wd), .ack_out(ack), .rdata_out(rd), .sw_store_in(st),
		.sw_recall_in(rc), .supply_low_in(low), .store_capacitor_pin_isolate_out(iso),
		.busy_out(busy), .dirty_out(dirty));
	nvssr_host_model u_nvssr_host_model (.ref_clk_in(clk), .ack_in(ack), .rdata_in(rd),
		.req_out(req), .we_out(we), .addr_out(addr), .wdata_out(wd));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic complete_run();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Edges until busy drops; acks seen while busy are counted
	task automatic idle_cnt(output int c);
		c = 0;
		for (int k = 1; k <= 50 && c == 0; k++)
		begin
			@(posedge clk);
			#1;
			if (busy === 1'b1 && ack === 1'b1)
				ack_busy++;
			if (busy === 1'b0)
				c = k;
		end
		if (c == 0)
		begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic acc(input logic w, input logic [NVSSR_ADDR_W-1:0] a,
		input logic [NVSSR_DATA_W-1:0] d);
		@(posedge clk);
		u_nvssr_host_model.access(w, a, d, q, ok);
		#1;
		`CHK("ack", 1'b1, ok)
	endtask
	task automatic s_reset();
		repeat (16) @(posedge clk);
		#1;
		`CHK("busy in reset", 1'b1, busy)
		`CHK("isolate in reset", 1'b0, iso)
		@(posedge clk);
		rst_n <= 1'b1;
		idle_cnt(n);
		`CHK("power-up recall", 4, n)
	endtask
	task automatic s_access();
		acc(1'b1, a_top, 8'ha5);
		`CHK("dirty", 1'b1, dirty)
		acc(1'b1, a_low, 8'h3c);
		acc(1'b0, a_top, 8'h00);
		`CHK("read top", 8'ha5, q)
	endtask
	task automatic s_store();
		@(posedge clk);
		st <= 1'b1;
		fork
			u_nvssr_host_model.access(1'b0, a_low, 8'h00, q, ok);
			begin
				@(posedge clk);
				st <= 1'b0;
				idle_cnt(n);
			end
		join
		#1;
		`CHK("store cycles", 10, n)
		`CHK("ack after store", 1'b1, ok)
		`CHK("ack while busy", 0, ack_busy)
		`CHK("read after store", 8'h3c, q)
		`CHK("dirty cleared", 1'b0, dirty)
		@(posedge clk);
		st <= 1'b1;
		@(posedge clk);
		st <= 1'b0;
		idle_cnt(n);
		`CHK("clean store cycles", 10, n)
	endtask
	task automatic s_recall();
		acc(1'b1, a_top, 8'h5a);
		@(posedge clk);
		rc <= 1'b1;
		@(posedge clk);
		rc <= 1'b0;
		idle_cnt(n);
		`CHK("recall cycles", 4, n)
		`CHK("dirty after recall", 1'b0, dirty)
		acc(1'b0, a_top, 8'h00);
		`CHK("recalled top", 8'ha5, q)
		acc(1'b0, a_low, 8'h00);
		`CHK("recalled low", 8'h3c, q)
	endtask
	// One power loss: dirty runs the store first, clean goes straight down
	task automatic s_power(input logic [NVSSR_DATA_W-1:0] d, input logic dirt);
		if (dirt)
			acc(1'b1, a_low, d);
		@(posedge clk);
		low <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("isolate", 1'b1, iso)
		`CHK("busy at loss", 1'b1, busy)
		// A short clean loss must reach the down state at once, with no store first
		repeat (dirt ? 10 : 1) @(posedge clk);
		#1;
		`CHK("dirty after loss", 1'b0, dirty)
		@(posedge clk);
		low <= 1'b0;
		idle_cnt(n);
		`CHK("power-up cycles", 5, n)
		`CHK("isolate off", 1'b0, iso)
		acc(1'b0, a_low, 8'h00);
		`CHK("kept byte", d, q)
	endtask
	initial
	begin
		rst_n = 1'b0;
		st = 1'b0;
		rc = 1'b0;
		low = 1'b0;
		s_reset();
		s_access();
		s_store();
		s_recall();
		s_power(8'h77, 1'b1);
		s_power(8'h77, 1'b0);
		complete_run();
	end
endmodule

// ==== test/nvssr_host_model.sv ====
module nvssr_host_model
	import nvssr_pkg::*;
(
	// Clock and answer
	input wire logic ref_clk_in,
	input wire logic ack_in,
	input wire logic [NVSSR_DATA_W-1:0] rdata_in,
	// Request
	output logic req_out,
	output logic we_out,
	output logic [NVSSR_ADDR_W-1:0] addr_out,
	output logic [NVSSR_DATA_W-1:0] wdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		req_out = 1'b0;
		we_out = 1'b0;
		addr_out = '0;
		wdata_out = '0;
	end
	// Call just after an edge; the request is held until ack is seen at an edge
	task automatic access(input logic w, input logic [NVSSR_ADDR_W-1:0] a,
		input logic [NVSSR_DATA_W-1:0] d, output logic [NVSSR_DATA_W-1:0] q, output bit ok);
		ok = 1'b0;
		req_out <= 1'b1;
		we_out <= w;
		addr_out <= a;
		wdata_out <= d;
		for (int n = 0; n < 40 && !ok; n++)
		begin
			@(posedge ref_clk_in);
			if (ack_in === 1'b1)
				ok = 1'b1;
		end
		q = rdata_in;
		req_out <= 1'b0;
		// Released lines show the inverse so stale values cannot pass
		addr_out <= ~a;
		wdata_out <= ~d;
		// Holding req at the ack edge yields one extra access; let its ack pass
		@(posedge ref_clk_in);
	endtask
endmodule
